// ==== core/cmp_bank.sv ====
// Four analogue and four digital comparators with delayed outputs and APB registers
`timescale 1ns/1ps
`include "cmp_delay_regs.svh"
module cmp_bank #(
	parameter int TICK_CYCLES  = `TICK_CYCLES,
	parameter int TENTH_CYCLES = `TENTH_CYCLES
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic [11:0]                  paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic [`N_SRC-1:0][`VAL_W-1:0] meas_value,
	input  wire logic [`N_SRC-1:0]            status_in,
	output logic [3:0]                        analog_cmp_out,
	output logic [3:0]                        analog_cmp_out_inv,
	output logic [3:0]                        digital_cmp_out
);
	// Thresholds at their defaults, hysteresis mode, zero delays
	// Inverted outputs start high so they complement the low outputs even in reset
	localparam cmp_delay_pkg::main_state_type RST_STATE = '{
		upper:   {4{`UPPER_RST}},
		lower:   {4{`LOWER_RST}},
		asrc:    {4{`ASRC_RST}},
		a_inv:   4'hf,
		default: '0
	};

	cmp_delay_pkg::main_state_type state_ff;
	cmp_delay_pkg::main_state_type nxt_state;
	cmp_delay_pkg::decode_type     dec;
	logic                          setup;
	logic                          wr_access;
	logic [1:0]                    ci;
	logic [3:0][`VAL_W-1:0]        val_w;
	logic [3:0]                    band_w;
	logic [3:0]                    dsel_w;
	logic [7:0]                    out_w;
	logic [7:0][`DLY_W-1:0]        tmr_w;

	function automatic logic above(input logic [`VAL_W-1:0] a, input logic [`VAL_W-1:0] b);
		return $signed(a) > $signed(b);
	endfunction

	function automatic logic in_band(
		input logic [`VAL_W-1:0] v,
		input logic [`VAL_W-1:0] lo,
		input logic [`VAL_W-1:0] hi
	);
		return !above(lo, v) && !above(v, hi);
	endfunction

	// Values beyond the longest delay are clamped instead of wrapping
	function automatic logic [`DLY_W-1:0] clamp_dly(input logic [31:0] w);
		logic [`DLY_W-1:0] r;
		r = `DLY_MAX;
		if (w < {13'h0, `DLY_MAX}) begin
			r = w[`DLY_W-1:0];
		end
		return r;
	endfunction

	function automatic cmp_delay_pkg::decode_type decode(input logic [11:0] a);
		cmp_delay_pkg::decode_type d;
		d.chan = '0;
		d.sel = cmp_delay_pkg::SEL_NONE;
		if (a[11:8] == `A_PAGE && !a[7]) begin
			d.chan = {1'b0, a[6:5]};
			case (a[4:0])
				`A_CFG:   d.sel = cmp_delay_pkg::SEL_CFG;
				`A_UPPER: d.sel = cmp_delay_pkg::SEL_UPPER;
				`A_LOWER: d.sel = cmp_delay_pkg::SEL_LOWER;
				`A_SET:   d.sel = cmp_delay_pkg::SEL_SET;
				`A_RES:   d.sel = cmp_delay_pkg::SEL_RES;
				`A_TMR:   d.sel = cmp_delay_pkg::SEL_TMR;
				default:  d.sel = cmp_delay_pkg::SEL_NONE;
			endcase
		end else if (a[11:8] == `D_PAGE && a[7:6] == 2'h0) begin
			d.chan = {1'b1, a[5:4]};
			case (a[3:0])
				`D_CFG:  d.sel = cmp_delay_pkg::SEL_CFG;
				`D_SET:  d.sel = cmp_delay_pkg::SEL_SET;
				`D_RES:  d.sel = cmp_delay_pkg::SEL_RES;
				`D_TMR:  d.sel = cmp_delay_pkg::SEL_TMR;
				default: d.sel = cmp_delay_pkg::SEL_NONE;
			endcase
		end else if (a == `STAT_ADDR) begin
			d.sel = cmp_delay_pkg::SEL_STAT;
		end
		return d;
	endfunction

	assign dec = decode(paddr);
	assign ci = dec.chan[1:0];
	assign setup = psel && !penable;
	assign wr_access = psel && penable && state_ff.pready && pwrite;

	for (genvar g = 0; g < 4; g++) begin : g_sel
		assign val_w[g] = meas_value[state_ff.asrc[g]];
		assign band_w[g] = in_band(val_w[g], state_ff.lower[g], state_ff.upper[g]);
		assign dsel_w[g] = status_in[state_ff.dsrc[g]];
	end

	always_comb begin
		nxt_state = state_ff;

		// Zero wait state slave: answer registered during setup
		nxt_state.pready = setup;
		nxt_state.pslverr = setup && dec.sel == cmp_delay_pkg::SEL_NONE;
		if (setup) begin
			nxt_state.prdata = '0;
			if (!pwrite) begin
				case (dec.sel)
					cmp_delay_pkg::SEL_CFG: begin
						if (dec.chan[2]) begin
							nxt_state.prdata[`CFG_SRC_LSB +: 4] = state_ff.dsrc[ci];
						end else begin
							nxt_state.prdata[`CFG_SRC_LSB +: 4] = state_ff.asrc[ci];
							nxt_state.prdata[`CFG_MODE_BIT] = state_ff.mode[ci];
						end
					end
					cmp_delay_pkg::SEL_UPPER: begin
						nxt_state.prdata[`VAL_W-1:0] = state_ff.upper[ci];
					end
					cmp_delay_pkg::SEL_LOWER: begin
						nxt_state.prdata[`VAL_W-1:0] = state_ff.lower[ci];
					end
					cmp_delay_pkg::SEL_SET: begin
						nxt_state.prdata[`DLY_W-1:0] = state_ff.set_dly[dec.chan];
					end
					cmp_delay_pkg::SEL_RES: begin
						nxt_state.prdata[`DLY_W-1:0] = state_ff.res_dly[dec.chan];
					end
					cmp_delay_pkg::SEL_TMR: begin
						nxt_state.prdata[`DLY_W-1:0] = tmr_w[dec.chan];
					end
					cmp_delay_pkg::SEL_STAT: begin
						nxt_state.prdata[11:0] = {state_ff.d_out, state_ff.a_inv, state_ff.a_out};
					end
					default: begin
						nxt_state.prdata = '0;
					end
				endcase
			end
		end

		// Timer and status registers ignore writes
		if (wr_access) begin
			case (dec.sel)
				cmp_delay_pkg::SEL_CFG: begin
					if (dec.chan[2]) begin
						nxt_state.dsrc[ci] = pwdata[`CFG_SRC_LSB +: 4];
					end else begin
						nxt_state.asrc[ci] = pwdata[`CFG_SRC_LSB +: 4];
						nxt_state.mode[ci] = pwdata[`CFG_MODE_BIT];
					end
				end
				cmp_delay_pkg::SEL_UPPER: begin
					nxt_state.upper[ci] = pwdata[`VAL_W-1:0];
				end
				cmp_delay_pkg::SEL_LOWER: begin
					nxt_state.lower[ci] = pwdata[`VAL_W-1:0];
				end
				cmp_delay_pkg::SEL_SET: begin
					nxt_state.set_dly[dec.chan] = clamp_dly(pwdata);
				end
				cmp_delay_pkg::SEL_RES: begin
					nxt_state.res_dly[dec.chan] = clamp_dly(pwdata);
				end
				default: begin
					nxt_state.mode = state_ff.mode;
				end
			endcase
		end

		// Update tick and tenth-second time base
		nxt_state.tick = 1'b0;
		nxt_state.tick_cnt = state_ff.tick_cnt + 32'h1;
		if (state_ff.tick_cnt == 32'(TICK_CYCLES - 1)) begin
			nxt_state.tick_cnt = '0;
			nxt_state.tick = 1'b1;
		end
		nxt_state.tenth = 1'b0;
		nxt_state.tenth_cnt = state_ff.tenth_cnt + 32'h1;
		if (state_ff.tenth_cnt == 32'(TENTH_CYCLES - 1)) begin
			nxt_state.tenth_cnt = '0;
			nxt_state.tenth = 1'b1;
		end
		// Timers act a cycle after the comparison so they see settled results
		nxt_state.upd = state_ff.tick;

		if (state_ff.tick) begin
			for (int i = 0; i < 4; i++) begin
				if (above(val_w[i], state_ff.upper[i])) begin
					nxt_state.hyst[i] = 1'b1;
				end else if (above(state_ff.lower[i], val_w[i]) &&
					!above(state_ff.lower[i], state_ff.upper[i])) begin
					nxt_state.hyst[i] = 1'b0;
				end
				if (state_ff.mode[i] == cmp_delay_pkg::MODE_WIN) begin
					nxt_state.raw[i] = band_w[i];
				end else begin
					nxt_state.raw[i] = nxt_state.hyst[i];
				end
				nxt_state.raw[4 + i] = dsel_w[i];
			end
		end

		nxt_state.a_out = out_w[3:0];
		nxt_state.a_inv = ~out_w[3:0];
		nxt_state.d_out = out_w[7:4];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= RST_STATE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Eight delay timers: analogue channels 0-3, digital channels 4-7
	delay_link_if dif[8] ();
	for (genvar g = 0; g < 8; g++) begin : g_dly
		assign dif[g].upd = state_ff.upd;
		assign dif[g].tenth = state_ff.tenth;
		assign dif[g].raw = state_ff.raw[g];
		assign dif[g].set_dly = state_ff.set_dly[g];
		assign dif[g].res_dly = state_ff.res_dly[g];
		assign out_w[g] = dif[g].out;
		assign tmr_w[g] = dif[g].timer;
		cmp_delay_timer u_dly (
			.pclk    (pclk),
			.presetn (presetn),
			.lnk     (dif[g])
		);
	end

	assign prdata = state_ff.prdata;
	assign pready = state_ff.pready;
	assign pslverr = state_ff.pslverr;
	assign analog_cmp_out = state_ff.a_out;
	assign analog_cmp_out_inv = state_ff.a_inv;
	assign digital_cmp_out = state_ff.d_out;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Cycles since the previous tick, for checking the tick period
	logic [31:0] gap_cnt;
	logic        gap_seen;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cnt <= '0;
			gap_seen <= 1'b0;
		end else if (state_ff.tick) begin
			gap_cnt <= '0;
			gap_seen <= 1'b1;
		end else begin
			gap_cnt <= gap_cnt + 32'h1;
		end
	end

	tick_period_a:
	assert property (state_ff.tick && gap_seen |-> gap_cnt == 32'(TICK_CYCLES - 1))
		else $error("update tick period wrong");
	inv_match_a: assert property (analog_cmp_out_inv == ~analog_cmp_out)
		else $error("inverted output not complement");
	apb_answer_a: assert property (setup |=> pready) else $error("setup not answered");

	for (genvar g = 0; g < 4; g++) begin : g_chk
		hyst_set_a:
		assert property (state_ff.tick && !state_ff.mode[g] &&
			above(val_w[g], state_ff.upper[g]) |=> state_ff.raw[g])
			else $error("hysteresis did not set");
		hyst_clear_a:
		assert property (state_ff.tick && !state_ff.mode[g] &&
			!above(val_w[g], state_ff.upper[g]) && above(state_ff.lower[g], val_w[g]) &&
			!above(state_ff.lower[g], state_ff.upper[g]) |=> !state_ff.raw[g])
			else $error("hysteresis did not clear");
		hyst_hold_a:
		assert property (state_ff.tick && !state_ff.mode[g] &&
			!above(val_w[g], state_ff.upper[g]) && !above(state_ff.lower[g], val_w[g])
			|=> $stable(state_ff.hyst[g]) && state_ff.raw[g] == state_ff.hyst[g])
			else $error("hysteresis did not hold");
		hyst_latch_a:
		assert property (state_ff.tick && !state_ff.mode[g] && state_ff.hyst[g] &&
			above(state_ff.lower[g], state_ff.upper[g]) |=> state_ff.raw[g] && state_ff.hyst[g])
			else $error("inverted thresholds did not latch");
		win_in_a:
		assert property (state_ff.tick && state_ff.mode[g] && band_w[g] |=> state_ff.raw[g])
			else $error("window inside not high");
		win_out_a:
		assert property (state_ff.tick && state_ff.mode[g] && !band_w[g] |=> !state_ff.raw[g])
			else $error("window outside not low");
		dig_follow_a:
		assert property (state_ff.tick |=> state_ff.raw[4 + g] == $past(dsel_w[g]))
			else $error("digital comparator not following input");
	end
endmodule

// ==== common/cmp_delay_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the comparator bank
`ifndef CMP_DELAY_REGS_SVH
`define CMP_DELAY_REGS_SVH
`define CLK_KHZ       40000
`define TICK_MS       8
`define TICK_CYCLES   (`TICK_MS * `CLK_KHZ)
`define TENTH_MS      100
`define TENTH_CYCLES  (`TENTH_MS * `CLK_KHZ)
`define VAL_W         16
`define N_SRC         16
`define DLY_W         19
`define DLY_MAX       19'h57e3f
`define UPPER_RST     16'h012c
`define LOWER_RST     16'h00c8
`define ASRC_RST      4'h4
`define A_PAGE        4'h0
`define D_PAGE        4'h1
`define STAT_ADDR     12'h200
`define A_CFG         5'h00
`define A_UPPER       5'h04
`define A_LOWER       5'h08
`define A_SET         5'h0c
`define A_RES         5'h10
`define A_TMR         5'h14
`define D_CFG         4'h0
`define D_SET         4'h4
`define D_RES         4'h8
`define D_TMR         4'hc
`define CFG_MODE_BIT  0
`define CFG_SRC_LSB   4
`endif

// ==== common/cmp_delay_pkg.sv ====
// Types shared by the comparator bank and its delay timers
`include "cmp_delay_regs.svh"
package cmp_delay_pkg;
	typedef enum logic {MODE_HYST = 1'b0, MODE_WIN = 1'b1} cmp_mode_type;
	typedef enum logic [2:0] {
		SEL_NONE, SEL_CFG, SEL_UPPER, SEL_LOWER, SEL_SET, SEL_RES, SEL_TMR, SEL_STAT
	} reg_sel_type;
	typedef struct packed {
		logic [2:0]  chan;
		reg_sel_type sel;
	} decode_type;
	typedef struct packed {
		logic                          pready;
		logic                          pslverr;
		logic [31:0]                   prdata;
		logic [31:0]                   tick_cnt;
		logic [31:0]                   tenth_cnt;
		logic                          tick;
		logic                          upd;
		logic                          tenth;
		logic [3:0]                    mode;
		logic [3:0][3:0]               asrc;
		logic [3:0][`VAL_W-1:0]        upper;
		logic [3:0][`VAL_W-1:0]        lower;
		logic [3:0][3:0]               dsrc;
		logic [7:0][`DLY_W-1:0]        set_dly;
		logic [7:0][`DLY_W-1:0]        res_dly;
		logic [3:0]                    hyst;
		logic [7:0]                    raw;
		logic [3:0]                    a_out;
		logic [3:0]                    a_inv;
		logic [3:0]                    d_out;
	} main_state_type;
	typedef struct packed {
		logic              out;
		logic [`DLY_W-1:0] timer;
	} dly_state_type;
endpackage

// ==== common/delay_link_if.sv ====
// Link between the comparator bank and one output delay timer
`timescale 1ns/1ps
`include "cmp_delay_regs.svh"
interface delay_link_if;
	logic              upd;
	logic              tenth;
	logic              raw;
	logic              out;
	logic [`DLY_W-1:0] set_dly;
	logic [`DLY_W-1:0] res_dly;
	logic [`DLY_W-1:0] timer;
	modport ctrl (output upd, tenth, raw, set_dly, res_dly, input out, timer);
	modport unit (input upd, tenth, raw, set_dly, res_dly, output out, timer);
endinterface

// ==== core/cmp_delay_timer.sv ====
// Set and reset delay of one comparator output, with elapsed timer
`timescale 1ns/1ps
`include "cmp_delay_regs.svh"
module cmp_delay_timer (
	input wire logic pclk,
	input wire logic presetn,
	delay_link_if.unit lnk
);
	cmp_delay_pkg::dly_state_type state_ff;
	cmp_delay_pkg::dly_state_type nxt_state;
	logic                         pend;
	logic [`DLY_W-1:0]            target;

	assign pend = lnk.raw != state_ff.out;
	assign target = lnk.raw ? lnk.set_dly : lnk.res_dly;

	always_comb begin
		nxt_state = state_ff;
		// Saturates so a stuck comparison cannot wrap the timer
		if (lnk.tenth && pend && state_ff.timer != `DLY_MAX) begin
			nxt_state.timer = state_ff.timer + 19'h1;
		end
		if (lnk.upd) begin
			if (!pend) begin
				nxt_state.timer = '0;
			end else if (state_ff.timer >= target) begin
				nxt_state.out = lnk.raw;
				nxt_state.timer = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign lnk.out = state_ff.out;
	assign lnk.timer = state_ff.timer;

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence fire_seq;
		lnk.upd && pend && state_ff.timer >= target;
	endsequence
	sequence wait_seq;
		lnk.upd && pend && state_ff.timer < target;
	endsequence

	dly_fire_a:
	assert property (fire_seq |=> lnk.out == $past(lnk.raw) && lnk.timer == '0)
		else $error("delay expired but output did not follow");
	dly_wait_a:
	assert property (wait_seq |=> $stable(lnk.out)) else $error("output moved before delay");
	dly_cancel_a:
	assert property (lnk.upd && !pend |=> lnk.timer == '0 && $stable(lnk.out))
		else $error("reverted comparison not cancelled");
	out_quiet_a:
	assert property (!lnk.upd |=> $stable(lnk.out)) else $error("output moved off update");
	timer_cap_a:
	assert property (lnk.timer <= `DLY_MAX) else $error("timer beyond range");
endmodule

// ==== tb/source_model.sv ====
// Measurement and status sources feeding the comparator bank
`timescale 1ns/1ps
`include "cmp_delay_regs.svh"
module source_model (
	input  wire logic                     pclk,
	output logic [`N_SRC-1:0][`VAL_W-1:0] meas_value,
	output logic [`N_SRC-1:0]             status_in
);
	// Sources keep their value across resets, like live measurements
	initial begin
		meas_value = '0;
		status_in = '0;
	end
	task automatic set_meas(input int k, input logic [`VAL_W-1:0] v);
		@(posedge pclk);
		meas_value[k] <= v;
	endtask
	task automatic set_status(input logic [`N_SRC-1:0] v);
		@(posedge pclk);
		status_in <= v;
	endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the comparator bank
`timescale 1ns/1ps
`include "cmp_delay_regs.svh"
module testbench;
	localparam int TICK  = 10;
	localparam int TENTH = 25;
	logic                         pclk;
	logic                         presetn;
	logic [11:0]                  paddr;
	logic                         psel;
	logic                         penable;
	logic                         pwrite;
	logic [31:0]                  pwdata;
	logic [31:0]                  prdata;
	logic                         pready;
	logic                         pslverr;
	logic [`N_SRC-1:0][`VAL_W-1:0] meas_value;
	logic [`N_SRC-1:0]            status_in;
	logic [3:0]                   analog_cmp_out;
	logic [3:0]                   analog_cmp_out_inv;
	logic [3:0]                   digital_cmp_out;
	int                           bad_count;
	int                           comparisons;
	int                           ch, cfg, i, lo, hi, v, span, s, seed;
	logic                         e, ne, err;
	logic [31:0]                  r, sv;
	logic [3:0]                   hst;
	cmp_bank #(.TICK_CYCLES(TICK), .TENTH_CYCLES(TENTH)) cmp_bank_inst (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .meas_value(meas_value), .status_in(status_in),
		.analog_cmp_out(analog_cmp_out), .analog_cmp_out_inv(analog_cmp_out_inv),
		.digital_cmp_out(digital_cmp_out)
	);
	source_model source_model_inst (
		.pclk(pclk), .meas_value(meas_value), .status_in(status_in)
	);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic end_of_test;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Request held until pready is seen high at a rising edge; data taken at that edge
	task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd_data, output logic rd_err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			end_of_test();
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        y;
		apb_xfer(1'b1, a, d, x, y);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic y;
		apb_xfer(1'b0, a, 32'h0, d, y);
	endtask
	function automatic logic [11:0] a_addr(input int c, input int off);
		return 12'(c * 32 + off);
	endfunction
	function automatic logic [11:0] d_addr(input int c, input int off);
		return 12'(256 + c * 16 + off);
	endfunction
	function automatic logic hyst_model(input logic prev, input int x, input int l, input int h);
		if (x > h) return 1'b1;
		if (x < l && l <= h) return 1'b0;
		return prev;
	endfunction
	function automatic logic out_bit(input int w);
		return (w < 4) ? analog_cmp_out[w] : digital_cmp_out[w - 4];
	endfunction
	// At least one full tick plus the output pipeline
	task automatic settle;
		repeat (TICK + 6) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic wait_out(input int w, input logic val, input int lim);
		int n;
		n = 0;
		while (out_bit(w) !== val && n < lim) begin
			@(negedge pclk);
			n++;
		end
		if (out_bit(w) !== val) begin
			bad_count++;
			end_of_test();
		end
	endtask
	initial begin
		bad_count = 0;
		comparisons = 0;
		hst = '0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		seed = $urandom(32'he04f);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (ch = 0; ch < 4; ch++) begin
			rd(a_addr(ch, `A_CFG), r);
			check("cfg_rst", r, {24'h0, `ASRC_RST, 4'h0});
			rd(a_addr(ch, `A_UPPER), r);
			check("upper_rst", r, {16'h0, `UPPER_RST});
			rd(a_addr(ch, `A_LOWER), r);
			check("lower_rst", r, {16'h0, `LOWER_RST});
			rd(a_addr(ch, `A_RES), r);
			check("res_rst", r, 32'h0);
			rd(d_addr(ch, `D_SET), r);
			check("dset_rst", r, 32'h0);
			rd(a_addr(ch, `A_SET), r);
			check("aset_rst", r, 32'h0);
			rd(d_addr(ch, `D_RES), r);
			check("dres_rst", r, 32'h0);
			rd(d_addr(ch, `D_TMR), r);
			check("dtmr_rst", r, 32'h0);
			rd(a_addr(ch, `A_TMR), r);
			check("tmr_rst", r, 32'h0);
		end
		rd(`STAT_ADDR, r);
		check("status_rst", r, 32'h0f0);
		apb_xfer(1'b0, 12'h300, 32'h0, r, err);
		check("unmapped_err", {31'h0, err}, 32'h1);
		check("unmapped_data", r, 32'h0);
		wr(a_addr(0, `A_TMR), 32'h5);
		rd(a_addr(0, `A_TMR), r);
		check("tmr_ro", r, 32'h0);
		// Modes: hysteresis, window, then hysteresis with lower above upper
		for (cfg = 0; cfg < 3; cfg++) begin
			for (ch = 0; ch < 4; ch++) begin
				lo = int'($urandom_range(400)) - 200;
				hi = (cfg == 2) ? lo - 30 : lo + 20 + int'($urandom_range(200));
				span = (hi > lo) ? hi - lo : lo - hi;
				wr(a_addr(ch, `A_CFG), 32'((ch + 8) << 4) | ((cfg == 1) ? 32'h1 : 32'h0));
				wr(a_addr(ch, `A_UPPER), {16'h0, hi[15:0]});
				wr(a_addr(ch, `A_LOWER), {16'h0, lo[15:0]});
				rd(a_addr(ch, `A_UPPER), r);
				check("upper_rb", r, {16'h0, hi[15:0]});
				for (i = 0; i < 9; i++) begin
					if (i == 0) begin
						v = (lo <= hi) ? lo - 10 : hi + 10;
					end else if (i == 3) begin
						v = hi;
					end else if (i == 6) begin
						v = lo;
					end else begin
						v = ((lo < hi) ? lo : hi) - 40 + int'($urandom_range(span + 80));
					end
					source_model_inst.set_meas(ch + 8, v[15:0]);
					settle();
					hst[ch] = hyst_model(hst[ch], v, lo, hi);
					e = (cfg == 1) ? (v >= lo && v <= hi) : hst[ch];
					ne = ~e;
					check("analog_out", analog_cmp_out[ch], e);
					check("analog_inv", analog_cmp_out_inv[ch], ne);
				end
			end
		end
		for (ch = 0; ch < 4; ch++) begin
			s = $urandom_range(15);
			wr(d_addr(ch, `D_CFG), 32'(s << 4));
			for (i = 0; i < 4; i++) begin
				sv = $urandom;
				sv[s] = i[0];
				source_model_inst.set_status(sv[15:0]);
				settle();
				check("digital_out", digital_cmp_out[ch], sv[s]);
			end
		end
		wr(a_addr(0, `A_CFG), 32'h80);
		wr(a_addr(0, `A_UPPER), 32'd300);
		wr(a_addr(0, `A_LOWER), 32'd200);
		source_model_inst.set_meas(8, 16'h0064);
		settle();
		wr(a_addr(0, `A_SET), 32'h0007ffff);
		rd(a_addr(0, `A_SET), r);
		check("set_clamp", r, {13'h0, `DLY_MAX});
		wr(a_addr(0, `A_SET), 32'h3);
		source_model_inst.set_meas(8, 16'h0190);
		repeat (40) @(posedge pclk);
		@(negedge pclk);
		check("set_pending", analog_cmp_out[0], 32'h0);
		rd(a_addr(0, `A_TMR), r);
		check("tmr_run", {31'h0, r >= 1 && r <= 3}, 32'h1);
		wait_out(0, 1'b1, 150);
		check("set_done", analog_cmp_out[0], 32'h1);
		rd(a_addr(0, `A_TMR), r);
		check("tmr_clr", r, 32'h0);
		wr(a_addr(0, `A_RES), 32'h2);
		source_model_inst.set_meas(8, 16'h0064);
		repeat (20) @(posedge pclk);
		@(negedge pclk);
		check("res_pending", analog_cmp_out[0], 32'h1);
		wait_out(0, 1'b0, 150);
		check("res_done", analog_cmp_out[0], 32'h0);
		source_model_inst.set_meas(8, 16'h0190);
		repeat (30) @(posedge pclk);
		source_model_inst.set_meas(8, 16'h0064);
		repeat (150) @(posedge pclk);
		@(negedge pclk);
		check("cancel_out", analog_cmp_out[0], 32'h0);
		rd(a_addr(0, `A_TMR), r);
		check("cancel_tmr", r, 32'h0);
		wr(d_addr(1, `D_CFG), 32'h30);
		source_model_inst.set_status(16'h0000);
		settle();
		wr(d_addr(1, `D_SET), 32'h2);
		source_model_inst.set_status(16'h0008);
		repeat (20) @(posedge pclk);
		@(negedge pclk);
		check("dset_pending", digital_cmp_out[1], 32'h0);
		wait_out(5, 1'b1, 150);
		check("dset_done", digital_cmp_out[1], 32'h1);
		wr(d_addr(1, `D_RES), 32'h2);
		source_model_inst.set_status(16'h0000);
		repeat (20) @(posedge pclk);
		@(negedge pclk);
		check("dres_pending", digital_cmp_out[1], 32'h1);
		wait_out(5, 1'b0, 150);
		check("dres_done", digital_cmp_out[1], 32'h0);
		end_of_test();
	end
endmodule
